//--- rfk_pkg.sv
// Purpose: Shared constants and types for the radio transmitter keying sequencer
// Assumes: aclk at 25 MHz; AXI4-Lite register access with 32-bit data
// Notes: Every offset, field position, reset value and timing count lives here
package rfk_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned LOCK_TIME_NS = 3000000;
    localparam int unsigned LOCK_CYCLES_DEF = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_CNT_W = 20;
    // Synthesiser model, VCO cycles counted in 1/16 units
    localparam int unsigned VCO_RATIO = 32;
    localparam int unsigned FRAC_BITS = 4;
    localparam logic [31:0] STEP_NOM = 32'(VCO_RATIO << FRAC_BITS);
    localparam logic [31:0] STEP_LOW = STEP_NOM - 32'h1;
    // Clock output divider: toggle every second crystal rise gives f/4
    localparam logic DIV_PHASE_LAST = 1'b1;
    // Input pin vector positions
    localparam int unsigned PIN_TX = 0;
    localparam int unsigned PIN_AMP = 1;
    localparam int unsigned PIN_SW_N = 2;
    localparam int unsigned PIN_XTAL = 3;
    localparam int unsigned PIN_W = 4;
    // Register map
    localparam int unsigned AXI_AW = 5;
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 5'h00;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 5'h04;
    localparam logic [AXI_AW-1:0] ADDR_VCO = 5'h08;
    localparam logic [AXI_AW-1:0] ADDR_RATIO = 5'h0c;
    localparam int unsigned CTRL_CLKOUT_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam logic [31:0] CTRL_MASK = 32'h00000001;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_LOCKED_BIT = 4;
    localparam int unsigned STAT_AMP_BIT = 5;
    localparam int unsigned STAT_LOW_BIT = 6;
    localparam int unsigned STAT_CLK_BIT = 7;
    localparam int unsigned STAT_OSC_BIT = 8;
    localparam int unsigned STAT_STANDBY_BIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_WARM = 4'h2,
        ST_READY = 4'h4,
        ST_TRANSMIT = 4'h8
    } rfk_state_t;
endpackage

//--- rfk_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the aclk domain
// Assumes: Inputs are slow levels or clocks well below aclk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module rfk_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta;
            logic next_meta;
            logic next_q;
            always_comb begin
                next_meta = d[i];
                next_q = meta;
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta <= 1'b0;
                    q[i] <= 1'b0;
                end else if (ce) begin
                    meta <= next_meta;
                    q[i] <= next_q;
                end
            end
        end
    endgenerate
endmodule

//--- rfk_regs.sv
// Purpose: AXI4-Lite slave holding the control register and reading status
// Assumes: One write and one read at most under way
// Notes: Unmapped or read-only writes answer SLVERR; ce low stalls all channels
`timescale 1ns/100ps
module rfk_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [rfk_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rfk_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] status,
    input wire logic [31:0] vco_count,
    output logic clkout_allow
);
    logic aw_held, w_held;
    logic [rfk_pkg::AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] ctrl;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [rfk_pkg::AXI_AW-1:0] next_aw_addr;
    logic [31:0] next_w_data, next_ctrl, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;

    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign clkout_allow = ctrl[rfk_pkg::CTRL_CLKOUT_BIT];

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_ctrl = ctrl;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // Write lands one cycle after both halves are held
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (aw_addr[rfk_pkg::AXI_AW-1:2] == rfk_pkg::ADDR_CTRL[rfk_pkg::AXI_AW-1:2]) begin
                next_bresp = rfk_pkg::RESP_OKAY;
                if (w_strb[0]) begin
                    next_ctrl = w_data & rfk_pkg::CTRL_MASK;
                end
            end else begin
                next_bresp = rfk_pkg::RESP_SLVERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = rfk_pkg::RESP_OKAY;
            case (s_axi_araddr[rfk_pkg::AXI_AW-1:2])
                rfk_pkg::ADDR_CTRL[rfk_pkg::AXI_AW-1:2]: next_rdata = ctrl;
                rfk_pkg::ADDR_STATUS[rfk_pkg::AXI_AW-1:2]: next_rdata = status;
                rfk_pkg::ADDR_VCO[rfk_pkg::AXI_AW-1:2]: next_rdata = vco_count;
                rfk_pkg::ADDR_RATIO[rfk_pkg::AXI_AW-1:2]: next_rdata = 32'(rfk_pkg::VCO_RATIO);
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = rfk_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            ctrl <= rfk_pkg::CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rfk_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= rfk_pkg::RESP_OKAY;
        end else if (ce) begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            ctrl <= next_ctrl;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule

//--- rfk_keying_seq.sv
// Purpose: Transmitter state control, crystal clock output and keying model
// Assumes: Enable, amplifier request, keying switch and crystal arrive as async pins
// Notes: Synthesiser output is modelled as a VCO cycle count in 1/16 units
// Function
// RULE1: With transmitter enable and amplifier request both low the block sits in standby with everything off.
// RULE2: Transmitter enable high with amplifier request low runs oscillator, synthesiser and clock driver, amplifier off.
// RULE3: Both inputs high also switch the power amplifier on.
// RULE4: The controller waits at least 3 ms after raising enable before using the clock or the amplifier.
// RULE5: For amplitude keying the controller toggles the amplifier request with the data.
// RULE6: For frequency keying the controller switches an extra crystal load capacitor to ground with the data.
// RULE7: The controller drives that capacitor switch from an open-drain port. The controller model drives key_switch_n high when released instead.
// RULE8: The carrier is lower while the keying switch is closed than while it is open.
// RULE9: The synthesiser runs at exactly 32 times the crystal frequency.
// RULE10: The controller clocks its serial unit from the returned clock through its first timer input.
// RULE11: The serial unit uses two-wire mode for amplitude and three-wire mode for frequency keying.
// RULE12: In frequency keying the amplifier request rises after the lock wait and before switch toggling.
// RULE13: After sending, the controller drops the amplifier request, returns to its own clock, then drops enable.
// RULE14: On key wake-up the controller runs the enable sequence from its internal oscillator.
// RULE15: The returned clock runs at one quarter of the crystal frequency.
// RULE16: The controller lock-wait timer keeps margin so the wait never drops below the minimum.
`timescale 1ns/100ps
module rfk_keying_seq #(
    parameter int unsigned LOCK_CYCLES = rfk_pkg::LOCK_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tx_enable,
    input wire logic amp_on_request,
    input wire logic key_switch_n,
    input wire logic xtal_in,
    output logic standby,
    output logic osc_run,
    output logic synth_run,
    output logic clkout_drv_en,
    output logic amp_run,
    output logic shift_low,
    output logic clk_out,
    output logic [31:0] rf_cycles,
    input wire logic [rfk_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rfk_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [rfk_pkg::LOCK_CNT_W-1:0] LOCK_LAST = rfk_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1);

    logic [rfk_pkg::PIN_W-1:0] pins_s;
    logic tx_s, amp_s, sw_closed_s, xtal_s;
    logic xtal_prev, xtal_rise;
    logic clkout_allow, locked, clk_run;
    logic [31:0] status;
    rfk_pkg::rfk_state_t state, next_state;
    logic [rfk_pkg::LOCK_CNT_W-1:0] lock_cnt, next_lock_cnt;
    logic div_phase, next_div_phase, next_clk_out;
    logic next_standby, next_osc_run, next_amp_run, next_shift_low;
    logic [31:0] next_rf_cycles;

    rfk_sync #(
        .W(rfk_pkg::PIN_W)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d({xtal_in, key_switch_n, amp_on_request, tx_enable}),
        .q(pins_s)
    );

    assign tx_s = pins_s[rfk_pkg::PIN_TX];
    assign amp_s = pins_s[rfk_pkg::PIN_AMP];
    // Open-drain switch: low level on the pin means capacitor grounded
    assign sw_closed_s = !pins_s[rfk_pkg::PIN_SW_N];
    assign xtal_s = pins_s[rfk_pkg::PIN_XTAL];
    assign xtal_rise = xtal_s && !xtal_prev;
    assign locked = (state == rfk_pkg::ST_READY) || (state == rfk_pkg::ST_TRANSMIT);
    // Clock only leaves once stable, so the serial unit never sees a wild edge
    assign clk_run = tx_s && locked && clkout_allow;
    assign synth_run = osc_run;
    assign clkout_drv_en = osc_run;

    // Lock tracking; the amplifier itself follows the pins directly
    always_comb begin
        next_state = state;
        next_lock_cnt = 20'h0;
        case (state)
            rfk_pkg::ST_STANDBY: begin
                if (tx_s) begin
                    next_state = rfk_pkg::ST_WARM;
                end
            end
            rfk_pkg::ST_WARM: begin
                if (!tx_s) begin
                    next_state = rfk_pkg::ST_STANDBY;
                end else if (lock_cnt == LOCK_LAST) begin
                    next_state = amp_s ? rfk_pkg::ST_TRANSMIT : rfk_pkg::ST_READY;
                end else begin
                    next_lock_cnt = lock_cnt + 20'h1;
                end
            end
            rfk_pkg::ST_READY: begin
                if (!tx_s) begin
                    next_state = rfk_pkg::ST_STANDBY;
                end else if (amp_s) begin
                    next_state = rfk_pkg::ST_TRANSMIT;
                end
            end
            rfk_pkg::ST_TRANSMIT: begin
                if (!tx_s) begin
                    next_state = rfk_pkg::ST_STANDBY;
                end else if (!amp_s) begin
                    next_state = rfk_pkg::ST_READY;
                end
            end
            default: next_state = rfk_pkg::ST_STANDBY;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= rfk_pkg::ST_STANDBY;
            lock_cnt <= 20'h0;
        end else if (ce) begin
            state <= next_state;
            lock_cnt <= next_lock_cnt;
        end
    end

    // Power domains, keying and divider
    always_comb begin
        next_standby = !tx_s && !amp_s; // [RULE1]
        next_osc_run = tx_s; // [RULE2]
        next_amp_run = tx_s && amp_s; // [RULE3]
        next_shift_low = tx_s && sw_closed_s; // [RULE8]
        next_div_phase = div_phase;
        next_clk_out = clk_out;
        if (!clk_run) begin
            next_div_phase = 1'b0;
            next_clk_out = 1'b0;
        end else if (xtal_rise) begin
            next_div_phase = !div_phase;
            if (div_phase == rfk_pkg::DIV_PHASE_LAST) begin
                next_clk_out = !clk_out; // [RULE15]
            end
        end
        next_rf_cycles = rf_cycles;
        if (!osc_run) begin
            next_rf_cycles = 32'h0;
        end else if (xtal_rise) begin
            // Closed switch pulls the reference down one sixteenth of a VCO cycle per crystal rise
            next_rf_cycles = rf_cycles + (shift_low ? rfk_pkg::STEP_LOW : rfk_pkg::STEP_NOM); // [RULE8] [RULE9]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xtal_prev <= 1'b0;
            standby <= 1'b1;
            osc_run <= 1'b0;
            amp_run <= 1'b0;
            shift_low <= 1'b0;
            div_phase <= 1'b0;
            clk_out <= 1'b0;
            rf_cycles <= 32'h0;
        end else if (ce) begin
            xtal_prev <= xtal_s;
            standby <= next_standby;
            osc_run <= next_osc_run;
            amp_run <= next_amp_run;
            shift_low <= next_shift_low;
            div_phase <= next_div_phase;
            clk_out <= next_clk_out;
            rf_cycles <= next_rf_cycles;
        end
    end

    always_comb begin
        status = 32'h0;
        status[rfk_pkg::STAT_STATE_LSB +: 4] = state;
        status[rfk_pkg::STAT_LOCKED_BIT] = locked;
        status[rfk_pkg::STAT_AMP_BIT] = amp_run;
        status[rfk_pkg::STAT_LOW_BIT] = shift_low;
        status[rfk_pkg::STAT_CLK_BIT] = clk_out;
        status[rfk_pkg::STAT_OSC_BIT] = osc_run;
        status[rfk_pkg::STAT_STANDBY_BIT] = standby;
    end

    rfk_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .status(status),
        .vco_count(rf_cycles),
        .clkout_allow(clkout_allow)
    );

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !ce);

    sequence s_idle_pins;
        !tx_s && !amp_s;
    endsequence
    sequence s_all_off;
        standby && !osc_run && !amp_run && !synth_run;
    endsequence

    property p_standby;
        s_idle_pins |=> s_all_off;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered with both pins low"); // [RULE1]

    property p_osc_only;
        tx_s && !amp_s |=> osc_run && synth_run && clkout_drv_en && !amp_run && !standby;
    endproperty
    a_osc_only: assert property (p_osc_only) else $error("oscillator-only state wrong"); // [RULE2]

    property p_amp_on;
        tx_s && amp_s |=> amp_run && osc_run && synth_run;
    endproperty
    a_amp_on: assert property (p_amp_on) else $error("amplifier not on with both pins high"); // [RULE3]

    property p_amp_needs_enable;
        amp_run |-> $past(tx_s) && $past(amp_s);
    endproperty
    a_amp_needs_enable: assert property (p_amp_needs_enable) else $error("amplifier on without both pins"); // [RULE3]

    property p_shift_low;
        xtal_rise && osc_run && shift_low |=> rf_cycles == $past(rf_cycles) + rfk_pkg::STEP_LOW;
    endproperty
    a_shift_low: assert property (p_shift_low) else $error("carrier not lowered with switch closed"); // [RULE8]

    property p_ratio;
        xtal_rise && osc_run && !shift_low |=> rf_cycles == $past(rf_cycles) + rfk_pkg::STEP_NOM;
    endproperty
    a_ratio: assert property (p_ratio) else $error("synthesiser step not 32 per crystal cycle"); // [RULE9]

    property p_div_toggle;
        clk_run && xtal_rise && div_phase |=> clk_out != $past(clk_out);
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("clock output missed its toggle"); // [RULE15]

    property p_div_hold;
        clk_run && !(xtal_rise && div_phase) |=> clk_out == $past(clk_out);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("clock output toggled early"); // [RULE15]

    property p_no_clk_unlocked;
        !locked |=> !clk_out;
    endproperty
    a_no_clk_unlocked: assert property (p_no_clk_unlocked) else $error("clock output before lock"); // [RULE2]

    property p_lock_wait;
        state == rfk_pkg::ST_WARM && lock_cnt != LOCK_LAST |=> !locked;
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("lock declared before wait ended"); // [RULE2]
endmodule

//--- rfk_ctrl_model.sv
// Purpose: Controller firmware model driving the transmitter control pins
// Assumes: Called from the bench through its tasks; pins change after aclk rise
// Notes: Keying switch is driven high when released in place of an open-drain pull-up, so released reads high
`timescale 1ns/100ps
module rfk_ctrl_model #(
    parameter int LOCK_WAIT = 60
) (
    input wire logic aclk,
    output logic tx_enable,
    output logic amp_on_request,
    output logic key_switch_n
);
    logic sw_drive;
    initial begin
        tx_enable = 1'b0;
        amp_on_request = 1'b0;
        sw_drive = 1'b0;
    end
    // Pulls low when keying, drives high when released in place of the pull-up
    assign key_switch_n = sw_drive ? 1'b0 : 1'b1;
    // Wake on key, run the sequence from the internal clock
    task enable();
        @(posedge aclk);
        tx_enable <= 1'b1;
    endtask
    // Margin above the lock count, since our own clock is inexact
    task lock_wait();
        repeat (LOCK_WAIT) @(posedge aclk);
    endtask
    // Amplifier keyed with data, raised only after the lock wait
    task amp(input logic b);
        @(posedge aclk);
        amp_on_request <= b;
    endtask
    // Load capacitor switched with data
    task key(input logic b);
        @(posedge aclk);
        sw_drive <= b;
    endtask
    // Amplifier off first, then enable
    task power_down();
        @(posedge aclk);
        sw_drive <= 1'b0;
        amp_on_request <= 1'b0;
        repeat (4) @(posedge aclk);
        tx_enable <= 1'b0;
    endtask
endmodule

//--- test_rfk_keying_seq.sv
// Purpose: Self-checking bench for the keying sequencer
// Assumes: Lock count shortened to 50; crystal period 320 ns
// Notes: Crystal stands still while the transmitter is disabled
`timescale 1ns/100ps
module test_rfk_keying_seq;
    logic aclk = 0, aresetn = 0, ce = 1, xtal_in = 0;
    logic [4:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic tx_en, amp_req, sw_n, standby, osc_run, synth_run, drv_en, amp_run, shift_low, clk_out;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] rf, rdata;
    logic [1:0] bresp, rresp;
    int n_fail = 0, checks_done = 0, cyc = 0;
    always #20 aclk = ~aclk;
    initial begin
        #7;
        forever begin
            #160;
            xtal_in = tx_en ? ~xtal_in : 1'b0;
        end
    end
    rfk_ctrl_model #(.LOCK_WAIT(60)) u_ctl (.aclk(aclk), .tx_enable(tx_en), .amp_on_request(amp_req),
        .key_switch_n(sw_n));
    rfk_keying_seq #(.LOCK_CYCLES(50)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .tx_enable(tx_en),
        .amp_on_request(amp_req), .key_switch_n(sw_n), .xtal_in(xtal_in), .standby(standby),
        .osc_run(osc_run), .synth_run(synth_run), .clkout_drv_en(drv_en), .amp_run(amp_run),
        .shift_low(shift_low), .clk_out(clk_out), .rf_cycles(rf), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task final_report();
        if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            final_report();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Ready sampled mid-cycle, stable until the next rise where the transfer lands
    task wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        bit pa, pw, pb, ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        pa = 1; pw = 1; pb = 1;
        while (pb) begin
            @(negedge aclk);
            ta = pa && awready === 1'b1;
            tw = pw && wready === 1'b1;
            tb = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
            if (ta) begin awvalid <= 0; pa = 0; end
            if (tw) begin wvalid <= 0; pw = 0; end
            if (tb) begin bready <= 0; pb = 0; end
        end
    endtask
    task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        bit pa, pr, ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        pa = 1; pr = 1;
        while (pr) begin
            @(negedge aclk);
            ta = pa && arready === 1'b1;
            tr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) begin arvalid <= 0; pa = 0; end
            if (tr) begin rready <= 0; pr = 0; end
        end
    endtask
    task wait4();
        repeat (4) @(posedge aclk);
        #1;
    endtask
    task rf_step(input logic [31:0] e);
        logic [31:0] a;
        @(rf);
        #1 a = rf;
        @(rf);
        #1 chk("rf step", e, rf - a);
    endtask
    task t_regs();
        logic [31:0] d;
        logic [1:0] r;
        chk("standby", 1, 32'(standby));
        chk("osc idle", 0, 32'(osc_run));
        chk("rf idle", 0, rf);
        rd(rfk_pkg::ADDR_CTRL, d, r);
        chk("ctrl reset", rfk_pkg::CTRL_RESET, d);
        rd(rfk_pkg::ADDR_RATIO, d, r);
        chk("ratio", 32'h20, d);
        rd(5'h10, d, r);
        chk("unmapped resp", 32'(rfk_pkg::RESP_SLVERR), 32'(r));
        wr(rfk_pkg::ADDR_STATUS, 32'hffffffff, r);
        chk("ro write resp", 32'(rfk_pkg::RESP_SLVERR), 32'(r));
    endtask
    task t_warm();
        logic [31:0] d;
        logic [1:0] r;
        int c0;
        u_ctl.enable();
        wait4();
        chk("osc", 1, 32'({osc_run, synth_run, drv_en} == 3'h7));
        chk("amp off", 0, 32'(amp_run));
        chk("clk before lock", 0, 32'(clk_out));
        u_ctl.lock_wait();
        rd(rfk_pkg::ADDR_STATUS, d, r);
        chk("state ready", 32'h4, d & 32'hf);
        @(posedge clk_out);
        #1 c0 = cyc;
        @(posedge clk_out);
        #1 chk("clk period", 32, 32'(cyc - c0));
        rf_step(32'd512);
    endtask
    task t_keying();
        logic [31:0] d;
        logic [1:0] r;
        u_ctl.amp(1'b1);
        wait4();
        chk("amp on", 1, 32'(amp_run));
        rd(rfk_pkg::ADDR_STATUS, d, r);
        chk("state tx", 32'h8, d & 32'hf);
        u_ctl.amp(1'b0);
        wait4();
        chk("amp keyed off", 0, 32'(amp_run));
        u_ctl.amp(1'b1);
        u_ctl.key(1'b1);
        wait4();
        chk("shift low", 1, 32'(shift_low));
        rf_step(32'd511);
        u_ctl.key(1'b0);
        wait4();
        rf_step(32'd512);
    endtask
    task t_ctrl();
        logic [1:0] r;
        logic [31:0] d;
        logic hi;
        // Low strobe lane off: write accepted but bit kept
        @(posedge aclk);
        wstrb <= 4'he;
        wr(rfk_pkg::ADDR_CTRL, 32'h0, r);
        chk("strobe resp", 32'(rfk_pkg::RESP_OKAY), 32'(r));
        rd(rfk_pkg::ADDR_CTRL, d, r);
        chk("strobe kept", 32'h1, d);
        wstrb <= 4'hf;
        wr(rfk_pkg::ADDR_CTRL, 32'h0, r);
        chk("ctrl resp", 32'(rfk_pkg::RESP_OKAY), 32'(r));
        hi = 0;
        repeat (40) begin
            @(negedge aclk);
            hi = hi | clk_out;
        end
        chk("clk gated", 0, 32'(hi));
        wr(rfk_pkg::ADDR_CTRL, 32'h1, r);
    endtask
    task t_ce();
        logic [31:0] a;
        @(posedge aclk);
        ce <= 0;
        repeat (2) @(posedge aclk);
        #1 a = rf;
        repeat (20) @(posedge aclk);
        #1 chk("rf frozen", a, rf);
        chk("ready dropped", 0, 32'(arready));
        @(posedge aclk);
        ce <= 1;
        wait4();
        rf_step(32'd512);
    endtask
    task t_down();
        u_ctl.power_down();
        wait4();
        chk("standby again", 1, 32'(standby));
        chk("clk stopped", 0, 32'(clk_out));
        chk("rf cleared", 0, rf);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1;
        t_regs();
        t_warm();
        t_keying();
        t_ctrl();
        t_ce();
        t_down();
        final_report();
    end
endmodule
